// ### common/aux_regs_pkg.sv
// Constants for the serial control port and the auxiliary converter registers.
// Assumes one system clock; serial pins synchronous to it.
// Functional notes
// - 10-bit results read as upper eight and lower two bits.
// - Control bit 7 hands one converter to the side port.
// - Control bit 6 picks the side port converter: low A, high B.
// - Bits 5, 2 pick internal reference for B, A; low is external.
// - Bits 4, 1 pick input one for B, A; low is input two.
// - Start bits 3, 0 launch conversions on B, A; read zero.
// - Converter clock is receive rate over two, or four with bit 0.
// - Three 8-bit level words reset zero; apply on write completion.
// - Update bit 7 low applies words on write; high holds them.
// - Update bits 2..0 one-shot apply pending C, B, A; read zero.
// - Power-down bits 2..0 disable levels C, B, A; default on.
// - Invert bits 4, 2, 0 invert level words C, B, A.
// - Density level: 12-bit word over two registers, reset zero.
// - Top register is read-only revision; writes do nothing.
// - Low enable frames transfers; data outputs float while high.
// - Serial clock up to 16 MHz; sample on rise, shift on fall.
// - Writes commit at rise 16, second byte at rise 24; short frames drop.
// - Shared pin is input only unless three-wire mode is set.
// - Header: read flag, two-byte flag, 6-bit address.
// - Bit order selectable; second byte to address minus or plus one.
// - Reads return one byte; three-wire pin turns after header.
package aux_regs_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [5:0] ADDR_RESULT_FIRST = 6'h1a;
  localparam logic [5:0] ADDR_RESULT_LAST = 6'h21;
  localparam logic [5:0] ADDR_CONV_CTRL = 6'h22;
  localparam logic [5:0] ADDR_CONV_CLOCK = 6'h23;
  localparam logic [5:0] ADDR_LEVEL_A = 6'h24;
  localparam logic [5:0] ADDR_LEVEL_B = 6'h25;
  localparam logic [5:0] ADDR_LEVEL_C = 6'h26;
  localparam logic [5:0] ADDR_LEVEL_UPDATE = 6'h27;
  localparam logic [5:0] ADDR_LEVEL_POWERDOWN = 6'h28;
  localparam logic [5:0] ADDR_LEVEL_INVERT = 6'h29;
  localparam logic [5:0] ADDR_DENSITY_A = 6'h2a;
  localparam logic [5:0] ADDR_DENSITY_B = 6'h2b;
  localparam logic [5:0] ADDR_TRIM_A = 6'h31;
  localparam logic [5:0] ADDR_TRIM_B = 6'h32;
  localparam logic [5:0] ADDR_REVISION = 6'h3f;

  // ==========================================================================
  // Field positions
  localparam int CTRL_SIDE_PORT_BIT = 7;
  localparam int CTRL_CHOICE_BIT = 6;
  localparam int CTRL_REF_B_BIT = 5;
  localparam int CTRL_IN_B_BIT = 4;
  localparam int CTRL_START_B_BIT = 3;
  localparam int CTRL_REF_A_BIT = 2;
  localparam int CTRL_IN_A_BIT = 1;
  localparam int CTRL_START_A_BIT = 0;
  localparam int CLOCK_QUARTER_BIT = 0;
  localparam int UPDATE_HOLD_BIT = 7;
  localparam int INV_C_BIT = 4;
  localparam int INV_B_BIT = 2;
  localparam int INV_A_BIT = 0;
  localparam int HDR_READ_BIT = 7;
  localparam int HDR_TWO_BYTE_BIT = 6;

  // Storable bits per register; others read zero
  localparam logic [7:0] CTRL_STORE_MASK = 8'hf6;
  localparam logic [7:0] CLOCK_MASK = 8'h01;
  localparam logic [7:0] UPDATE_MASK = 8'h80;
  localparam logic [7:0] POWERDOWN_MASK = 8'h07;
  localparam logic [7:0] INVERT_MASK = 8'h15;

  // ==========================================================================
  // Reset values and counts
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RESET_RESULT = 10'h000;
  localparam logic [4:0] HEADER_LAST_EDGE = 5'h07;
  localparam logic [4:0] FIRST_COMMIT_EDGE = 5'h0f;
  localparam logic [4:0] SECOND_COMMIT_EDGE = 5'h17;
  localparam logic [2:0] OUT_LAST_BIT = 3'h7;
  localparam logic [1:0] DIV_HALF_LAST = 2'h1;
  localparam logic [1:0] DIV_QUARTER_LAST = 2'h3;

  // Frame states, Gray coded along idle, header, data, end
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HEAD = 2'b01,
    ST_DATA = 2'b11,
    ST_END = 2'b10
  } frame_state_t;

endpackage : aux_regs_pkg

// ### core/aux_serial_regs.sv
// Serial control port with the auxiliary converter register set.
// Assumes SCLK and enable are sampled on a much faster CLK.
`timescale 1ns/10ps
`default_nettype none

module aux_serial_regs
  import aux_regs_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h01 // Arbitrary value
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SERIAL_ENABLE_N,
  input wire logic SCLK,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE,
  output logic SERIAL_DATA_OUT,
  output logic SERIAL_DATA_OUT_OE,
  input wire logic LSB_FIRST,
  input wire logic THREE_WIRE_SELECT,
  input wire logic RX_RATE_TICK,
  output logic AUX_CLK_TICK,
  output logic CONV_A_START,
  output logic CONV_B_START,
  input wire logic CONV_A_DONE,
  input wire logic CONV_B_DONE,
  input wire logic [9:0] CONV_A_DATA,
  input wire logic [9:0] CONV_B_DATA,
  output logic CONV_A_INPUT_ONE,
  output logic CONV_B_INPUT_ONE,
  output logic CONV_A_INTERNAL_REF,
  output logic CONV_B_INTERNAL_REF,
  output logic SIDE_PORT_ENABLE,
  output logic SIDE_PORT_CONVERTER_CHOICE,
  output logic [7:0] LEVEL_A,
  output logic [7:0] LEVEL_B,
  output logic [7:0] LEVEL_C,
  output logic [2:0] LEVEL_POWERDOWN,
  output logic [11:0] DENSITY_LEVEL_WORD,
  output logic [7:0] RECEIVE_BIAS_TRIM_A,
  output logic [7:0] RECEIVE_BIAS_TRIM_B
);

  // ==========================================================================
  // Declarations
  frame_state_t state_q;
  frame_state_t state_d;
  logic sclk_q;
  logic sclk_rise;
  logic sclk_fall;
  logic [4:0] edge_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] head_q;
  logic [7:0] head_now;
  logic read_active_q;
  logic [7:0] rd_byte_q;
  logic [2:0] out_cnt_q;
  logic out_bit_q;
  logic wr_en;
  logic [5:0] wr_addr;
  logic [5:0] second_addr;
  logic [7:0] ctrl_q;
  logic [7:0] clock_q;
  logic [7:0] update_q;
  logic [7:0] powerdown_q;
  logic [7:0] invert_q;
  logic [7:0] pend_a_q;
  logic [7:0] pend_b_q;
  logic [7:0] pend_c_q;
  logic [7:0] live_a_q;
  logic [7:0] live_b_q;
  logic [7:0] live_c_q;
  logic [7:0] density_a_q;
  logic [7:0] density_b_q;
  logic [7:0] trim_a_q;
  logic [7:0] trim_b_q;
  logic [1:0] div_q;
  logic sel_a_one_q;
  logic sel_b_one_q;
  logic [9:0] result_q [0:3];
  logic [7:0] rd_mux;
  logic apply_a;
  logic apply_b;
  logic apply_c;

  // ==========================================================================
  // Serial clock edge detection, only inside a frame
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= SCLK;
    end
  end

  assign sclk_rise = SCLK & ~sclk_q & ~SERIAL_ENABLE_N;
  assign sclk_fall = ~SCLK & sclk_q & ~SERIAL_ENABLE_N;

  // Incoming bit joins the shift register in the selected order
  always_comb begin
    if (LSB_FIRST) begin
      shift_d = {SDIO_I, shift_q[7:1]};
    end else begin
      shift_d = {shift_q[6:0], SDIO_I};
    end
  end

  // Header as it stands after the eighth bit
  assign head_now = (edge_cnt_q == HEADER_LAST_EDGE) ? shift_d : head_q;

  // ==========================================================================
  // Frame state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (!SERIAL_ENABLE_N) begin
          state_d = ST_HEAD;
        end
      end
      ST_HEAD: begin
        if (sclk_rise && edge_cnt_q == HEADER_LAST_EDGE) begin
          state_d = ST_DATA;
        end
      end
      ST_DATA: begin
        if (sclk_rise && edge_cnt_q == FIRST_COMMIT_EDGE &&
            (head_q[HDR_READ_BIT] || !head_q[HDR_TWO_BYTE_BIT])) begin
          state_d = ST_END;
        end else if (sclk_rise && edge_cnt_q == SECOND_COMMIT_EDGE) begin
          state_d = ST_END;
        end
      end
      default: begin
        state_d = ST_END;
      end
    endcase
    if (SERIAL_ENABLE_N) begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Rising edge count, shift register and header capture
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      edge_cnt_q <= 5'h00;
      shift_q <= RESET_BYTE;
      head_q <= RESET_BYTE;
    end else if (SERIAL_ENABLE_N) begin
      edge_cnt_q <= 5'h00;
    end else if (sclk_rise) begin
      shift_q <= shift_d;
      head_q <= head_now;
      if (edge_cnt_q != 5'h1f) begin
        edge_cnt_q <= edge_cnt_q + 5'h01;
      end
    end
  end

  // ==========================================================================
  // Write commit strobe, address and second address
  assign second_addr = LSB_FIRST ? head_q[5:0] + 6'h01 :
                       head_q[5:0] - 6'h01;

  always_comb begin
    wr_en = 1'b0;
    wr_addr = head_q[5:0];
    if (state_q == ST_DATA && sclk_rise && !head_q[HDR_READ_BIT]) begin
      if (edge_cnt_q == FIRST_COMMIT_EDGE) begin
        wr_en = 1'b1;
      end else if (edge_cnt_q == SECOND_COMMIT_EDGE &&
                   head_q[HDR_TWO_BYTE_BIT]) begin
        wr_en = 1'b1;
        wr_addr = second_addr;
      end
    end
  end

  // ==========================================================================
  // Converter control, clock select, update hold, power-down, invert
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_q <= RESET_BYTE;
      clock_q <= RESET_BYTE;
      update_q <= RESET_BYTE;
      powerdown_q <= RESET_BYTE;
      invert_q <= RESET_BYTE;
    end else if (wr_en) begin
      if (wr_addr == ADDR_CONV_CTRL) begin
        ctrl_q <= shift_d & CTRL_STORE_MASK;
      end else if (wr_addr == ADDR_CONV_CLOCK) begin
        clock_q <= shift_d & CLOCK_MASK;
      end else if (wr_addr == ADDR_LEVEL_UPDATE) begin
        update_q <= shift_d & UPDATE_MASK;
      end else if (wr_addr == ADDR_LEVEL_POWERDOWN) begin
        powerdown_q <= shift_d & POWERDOWN_MASK;
      end else if (wr_addr == ADDR_LEVEL_INVERT) begin
        invert_q <= shift_d & INVERT_MASK;
      end
    end
  end

  // Converter routing and side port handover
  assign SIDE_PORT_ENABLE = ctrl_q[CTRL_SIDE_PORT_BIT];
  assign SIDE_PORT_CONVERTER_CHOICE = ctrl_q[CTRL_CHOICE_BIT];
  assign CONV_A_INTERNAL_REF = ctrl_q[CTRL_REF_A_BIT];
  assign CONV_B_INTERNAL_REF = ctrl_q[CTRL_REF_B_BIT];
  assign CONV_A_INPUT_ONE = ctrl_q[CTRL_IN_A_BIT];
  assign CONV_B_INPUT_ONE = ctrl_q[CTRL_IN_B_BIT];

  // Start one-shots from flops
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CONV_A_START <= 1'b0;
      CONV_B_START <= 1'b0;
    end else begin
      CONV_A_START <= wr_en && wr_addr == ADDR_CONV_CTRL &&
                      shift_d[CTRL_START_A_BIT];
      CONV_B_START <= wr_en && wr_addr == ADDR_CONV_CTRL &&
                      shift_d[CTRL_START_B_BIT];
    end
  end

  // Converter clock enable from receive ticks
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      div_q <= 2'h0;
      AUX_CLK_TICK <= 1'b0;
    end else begin
      AUX_CLK_TICK <= 1'b0;
      if (RX_RATE_TICK) begin
        if (div_q >= (clock_q[CLOCK_QUARTER_BIT] ? DIV_QUARTER_LAST :
                      DIV_HALF_LAST)) begin
          div_q <= 2'h0;
          AUX_CLK_TICK <= 1'b1;
        end else begin
          div_q <= div_q + 2'h1;
        end
      end
    end
  end

  // ==========================================================================
  // Input choice held from each conversion start
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel_a_one_q <= 1'b0;
      sel_b_one_q <= 1'b0;
    end else begin
      if (CONV_A_START) begin
        sel_a_one_q <= ctrl_q[CTRL_IN_A_BIT];
      end
      if (CONV_B_START) begin
        sel_b_one_q <= ctrl_q[CTRL_IN_B_BIT];
      end
    end
  end

  // Slots: 0 A input two, 1 A input one, 2 B input two, 3 B input one
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < 4; i++) begin
        result_q[i] <= RESET_RESULT;
      end
    end else begin
      if (CONV_A_DONE) begin
        result_q[{1'b0, sel_a_one_q}] <= CONV_A_DATA;
      end
      if (CONV_B_DONE) begin
        result_q[{1'b1, sel_b_one_q}] <= CONV_B_DATA;
      end
    end
  end

  // ==========================================================================
  // Level words: pending copies and the words in effect
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pend_a_q <= RESET_BYTE;
      pend_b_q <= RESET_BYTE;
      pend_c_q <= RESET_BYTE;
    end else if (wr_en) begin
      if (wr_addr == ADDR_LEVEL_A) begin
        pend_a_q <= shift_d;
      end else if (wr_addr == ADDR_LEVEL_B) begin
        pend_b_q <= shift_d;
      end else if (wr_addr == ADDR_LEVEL_C) begin
        pend_c_q <= shift_d;
      end
    end
  end

  // Apply on write, or on update one-shot in hold mode
  always_comb begin
    apply_a = 1'b0;
    apply_b = 1'b0;
    apply_c = 1'b0;
    if (wr_en && wr_addr == ADDR_LEVEL_UPDATE && update_q[UPDATE_HOLD_BIT]) begin
      apply_a = shift_d[0];
      apply_b = shift_d[1];
      apply_c = shift_d[2];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      live_a_q <= RESET_BYTE;
      live_b_q <= RESET_BYTE;
      live_c_q <= RESET_BYTE;
    end else begin
      if (wr_en && wr_addr == ADDR_LEVEL_A && !update_q[UPDATE_HOLD_BIT]) begin
        live_a_q <= shift_d;
      end else if (apply_a) begin
        live_a_q <= pend_a_q;
      end
      if (wr_en && wr_addr == ADDR_LEVEL_B && !update_q[UPDATE_HOLD_BIT]) begin
        live_b_q <= shift_d;
      end else if (apply_b) begin
        live_b_q <= pend_b_q;
      end
      if (wr_en && wr_addr == ADDR_LEVEL_C && !update_q[UPDATE_HOLD_BIT]) begin
        live_c_q <= shift_d;
      end else if (apply_c) begin
        live_c_q <= pend_c_q;
      end
    end
  end

  // Level outputs with optional inversion
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      LEVEL_A <= RESET_BYTE;
      LEVEL_B <= RESET_BYTE;
      LEVEL_C <= RESET_BYTE;
    end else begin
      LEVEL_A <= invert_q[INV_A_BIT] ? ~live_a_q : live_a_q;
      LEVEL_B <= invert_q[INV_B_BIT] ? ~live_b_q : live_b_q;
      LEVEL_C <= invert_q[INV_C_BIT] ? ~live_c_q : live_c_q;
    end
  end

  assign LEVEL_POWERDOWN = powerdown_q[2:0];

  // ==========================================================================
  // Density word and receive bias trims
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      density_a_q <= RESET_BYTE;
      density_b_q <= RESET_BYTE;
      trim_a_q <= RESET_BYTE;
      trim_b_q <= RESET_BYTE;
    end else if (wr_en) begin
      if (wr_addr == ADDR_DENSITY_A) begin
        density_a_q <= shift_d;
      end else if (wr_addr == ADDR_DENSITY_B) begin
        density_b_q <= shift_d & 8'h0f;
      end else if (wr_addr == ADDR_TRIM_A) begin
        trim_a_q <= shift_d;
      end else if (wr_addr == ADDR_TRIM_B) begin
        trim_b_q <= shift_d;
      end
    end
  end

  // Upper eight bits first register, lower four second
  assign DENSITY_LEVEL_WORD = {density_a_q, density_b_q[3:0]};
  assign RECEIVE_BIAS_TRIM_A = trim_a_q;
  assign RECEIVE_BIAS_TRIM_B = trim_b_q;

  // ==========================================================================
  // Readback multiplexer
  always_comb begin
    logic [2:0] off;
    off = 3'(head_now[5:0] - ADDR_RESULT_FIRST);
    rd_mux = RESET_BYTE;
    if (head_now[5:0] >= ADDR_RESULT_FIRST &&
        head_now[5:0] <= ADDR_RESULT_LAST) begin
      if (!off[0]) begin
        rd_mux = result_q[off[2:1]][9:2];
      end else begin
        rd_mux = {6'h00, result_q[off[2:1]][1:0]};
      end
    end else if (head_now[5:0] == ADDR_CONV_CTRL) begin
      rd_mux = ctrl_q;
    end else if (head_now[5:0] == ADDR_CONV_CLOCK) begin
      rd_mux = clock_q;
    end else if (head_now[5:0] == ADDR_LEVEL_A) begin
      rd_mux = pend_a_q;
    end else if (head_now[5:0] == ADDR_LEVEL_B) begin
      rd_mux = pend_b_q;
    end else if (head_now[5:0] == ADDR_LEVEL_C) begin
      rd_mux = pend_c_q;
    end else if (head_now[5:0] == ADDR_LEVEL_UPDATE) begin
      rd_mux = update_q;
    end else if (head_now[5:0] == ADDR_LEVEL_POWERDOWN) begin
      rd_mux = powerdown_q;
    end else if (head_now[5:0] == ADDR_LEVEL_INVERT) begin
      rd_mux = invert_q;
    end else if (head_now[5:0] == ADDR_DENSITY_A) begin
      rd_mux = density_a_q;
    end else if (head_now[5:0] == ADDR_DENSITY_B) begin
      rd_mux = density_b_q;
    end else if (head_now[5:0] == ADDR_TRIM_A) begin
      rd_mux = trim_a_q;
    end else if (head_now[5:0] == ADDR_TRIM_B) begin
      rd_mux = trim_b_q;
    end else if (head_now[5:0] == ADDR_REVISION) begin
      rd_mux = REVISION_CODE;
    end
  end

  // ==========================================================================
  // Read byte captured at the eighth rising edge
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      read_active_q <= 1'b0;
      rd_byte_q <= RESET_BYTE;
    end else if (SERIAL_ENABLE_N) begin
      read_active_q <= 1'b0;
    end else if (state_q == ST_HEAD && sclk_rise &&
                 edge_cnt_q == HEADER_LAST_EDGE && shift_d[HDR_READ_BIT]) begin
      read_active_q <= 1'b1;
      rd_byte_q <= rd_mux;
    end
  end

  // Output bits change on falling edges, in the selected order
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      out_cnt_q <= 3'h0;
      out_bit_q <= 1'b0;
    end else if (!read_active_q) begin
      out_cnt_q <= 3'h0;
    end else if (sclk_fall) begin
      out_bit_q <= LSB_FIRST ? rd_byte_q[out_cnt_q] :
                   rd_byte_q[OUT_LAST_BIT - out_cnt_q];
      if (out_cnt_q != OUT_LAST_BIT) begin
        out_cnt_q <= out_cnt_q + 3'h1;
      end
    end
  end

  // Pin drivers; both float whenever the enable is high
  assign SDIO_O = out_bit_q;
  assign SERIAL_DATA_OUT = out_bit_q;
  assign SDIO_OE = read_active_q & THREE_WIRE_SELECT &
                   ~SERIAL_ENABLE_N;
  assign SERIAL_DATA_OUT_OE = read_active_q & ~THREE_WIRE_SELECT &
                              ~SERIAL_ENABLE_N;

endmodule : aux_serial_regs

`default_nettype wire

// ### bench/serial_host_model.sv
// Host model: frames serial transfers and gathers readback bits.
// Assumes the bench resolves the data wires and sets the modes.
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input wire logic clk,
  input wire logic lsb_first,
  input wire logic three_wire,
  input wire logic sdio_wire,
  input wire logic sdo_wire,
  output logic sen_n,
  output logic sclk,
  output logic sdio_drv
);
  localparam int HALF = 8; // 32 ns half period, under 16 MHz

  // Idle pins: enable high, serial clock parked low
  initial begin
    sen_n = 1'b1;
    sclk = 1'b0;
    sdio_drv = 1'b0;
  end

  // Let edges pass, then step off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // One frame of nrise rising edges: header, first byte, second byte
  task automatic xfer(input logic [7:0] hdr, input logic [15:0] dat,
    input int nrise, output logic [7:0] rd);
    logic [23:0] f;
    int k;
    f = {hdr, dat};
    rd = 8'h00;
    tick(1);
    sen_n = 1'b0;
    for (int i = 0; i < nrise; i++) begin
      k = lsb_first ? i / 8 * 8 + 7 - i % 8 : i;
      sclk = 1'b0;
      sdio_drv = (hdr[7] && i > 7) ? ~sdio_drv : f[23 - k];
      tick(HALF);
      if (i > 7) begin
        rd[lsb_first ? i - 8 : 15 - i] = three_wire ? sdio_wire : sdo_wire;
      end
      sclk = 1'b1;
      tick(HALF);
    end
    sclk = 1'b0;
    tick(HALF);
    sen_n = 1'b1;
    sdio_drv = ~sdio_drv;
  endtask : xfer
endmodule : serial_host_model
`default_nettype wire

// ### bench/aux_serial_regs_assertions.sv
// Checker for the serial control port register block.
// Bound to the top module; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module aux_serial_regs_assertions (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SERIAL_ENABLE_N,
  input wire logic SCLK,
  input wire logic SDIO_OE,
  input wire logic SERIAL_DATA_OUT,
  input wire logic SERIAL_DATA_OUT_OE,
  input wire logic THREE_WIRE_SELECT,
  input wire logic RX_RATE_TICK,
  input wire logic AUX_CLK_TICK,
  input wire logic CONV_A_START,
  input wire logic CONV_B_START,
  input wire logic SIDE_PORT_ENABLE,
  input wire logic [7:0] LEVEL_A,
  input wire logic [7:0] LEVEL_C,
  input wire logic [2:0] LEVEL_POWERDOWN,
  input wire logic [11:0] DENSITY_LEVEL_WORD
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic [2:0] rx_cnt_q;
  logic oe;
  assign oe = SDIO_OE || SERIAL_DATA_OUT_OE;

  // ==========================================================
  // Receive ticks since the last converter tick
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      rx_cnt_q <= 3'h0;
    end else if (AUX_CLK_TICK) begin
      rx_cnt_q <= {2'b00, RX_RATE_TICK};
    end else if (RX_RATE_TICK && rx_cnt_q != 3'h7) begin
      rx_cnt_q <= rx_cnt_q + 3'h1;
    end
  end

  // ==========================================================
  // Properties
  a_idle_float: assert property (
    SERIAL_ENABLE_N |-> !oe) else $error("Driven while idle");
  a_shared_pin_mode: assert property (
    SDIO_OE |-> THREE_WIRE_SELECT) else $error("Shared pin in 4-wire");
  a_out_pin_mode: assert property (
    SERIAL_DATA_OUT_OE |-> !THREE_WIRE_SELECT) else $error("Out pin 3-wire");
  a_start_one_shot: assert property (
    (CONV_A_START || CONV_B_START) |-> !SERIAL_ENABLE_N ##1
    !(CONV_A_START || CONV_B_START)) else $error("Bad start pulse");
  a_tick_ratio: assert property (
    AUX_CLK_TICK |-> rx_cnt_q == 3'h2 || rx_cnt_q == 3'h4)
    else $error("Bad clock ratio");
  a_tick_cause: assert property (
    AUX_CLK_TICK |-> $past(RX_RATE_TICK)) else $error("Tick without cause");
  a_cfg_in_frame: assert property (
    $changed({LEVEL_POWERDOWN, SIDE_PORT_ENABLE}) |-> !SERIAL_ENABLE_N)
    else $error("Setting moved outside frame");
  a_level_on_rise: assert property (
    $changed({LEVEL_A, LEVEL_C, DENSITY_LEVEL_WORD})
    |-> SCLK && !SERIAL_ENABLE_N) else $error("Level moved off edge");
  a_turn_after_head: assert property (
    $rose(oe) |-> SCLK && !SERIAL_ENABLE_N) else $error("Early turn");
  a_bit_on_fall: assert property (
    SERIAL_DATA_OUT_OE && $past(SERIAL_DATA_OUT_OE) &&
    $changed(SERIAL_DATA_OUT) |-> !SCLK) else $error("Bit moved off fall");
  a_hold_to_end: assert property (
    $fell(oe) |-> SERIAL_ENABLE_N) else $error("Output dropped in frame");

  // Main scenarios reached
  c_start: cover property (CONV_A_START);
  c_three_wire: cover property ($rose(SDIO_OE));
  c_four_wire: cover property ($rose(SERIAL_DATA_OUT_OE));
endmodule : aux_serial_regs_assertions
bind aux_serial_regs aux_serial_regs_assertions chk (.*);
`default_nettype wire

// ### bench/serial_control_port_aux_regs_tb_top.sv
// Self-checking bench for the serial control port register block.
// Assumes the host model drives serial pins; bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module serial_control_port_aux_regs_tb_top
  import aux_regs_pkg::*;
;
  localparam logic [7:0] REV = 8'h5a; // Arbitrary value
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic LSB_FIRST = 1'b0;
  logic THREE_WIRE_SELECT = 1'b0;
  logic RX_RATE_TICK = 1'b0;
  logic CONV_A_DONE = 1'b0;
  logic CONV_B_DONE = 1'b0;
  logic [9:0] CONV_A_DATA = 10'h000;
  logic [9:0] CONV_B_DATA = 10'h000;
  logic SERIAL_ENABLE_N, SCLK, SDIO_I, SDIO_O, SDIO_OE, SERIAL_DATA_OUT;
  logic SERIAL_DATA_OUT_OE, AUX_CLK_TICK, CONV_A_START, CONV_B_START;
  logic CONV_A_INPUT_ONE, CONV_B_INPUT_ONE, CONV_A_INTERNAL_REF, drv;
  logic CONV_B_INTERNAL_REF, SIDE_PORT_ENABLE, SIDE_PORT_CONVERTER_CHOICE;
  logic [7:0] LEVEL_A, LEVEL_B, LEVEL_C, RECEIVE_BIAS_TRIM_A, rd, x;
  logic [7:0] RECEIVE_BIAS_TRIM_B;
  logic [2:0] LEVEL_POWERDOWN;
  logic [11:0] DENSITY_LEVEL_WORD;
  logic [9:0] r;
  logic [5:0] a, ctrl;
  int error_cnt = 0;
  int checks = 0;
  int starts = 0;
  logic [5:0] rw_addr [8] = '{ADDR_LEVEL_A, ADDR_LEVEL_B, ADDR_LEVEL_C,
    ADDR_LEVEL_POWERDOWN, ADDR_DENSITY_A, ADDR_DENSITY_B, ADDR_TRIM_A,
    ADDR_TRIM_B};

  // Wires, clock and the two parties
  assign SDIO_I = SDIO_OE ? SDIO_O : drv;
  assign ctrl = {SIDE_PORT_ENABLE, SIDE_PORT_CONVERTER_CHOICE,
    CONV_B_INTERNAL_REF, CONV_B_INPUT_ONE, CONV_A_INTERNAL_REF,
    CONV_A_INPUT_ONE};
  always #2 CLK = ~CLK;
  aux_serial_regs #(.REVISION_CODE(REV)) dut (.*);
  serial_host_model host (.clk(CLK), .lsb_first(LSB_FIRST),
    .three_wire(THREE_WIRE_SELECT), .sdio_wire(SDIO_I),
    .sdo_wire(SERIAL_DATA_OUT_OE ? SERIAL_DATA_OUT : 1'bz),
    .sen_n(SERIAL_ENABLE_N), .sclk(SCLK), .sdio_drv(drv));

  // Receive rate tick every third cycle; start pulse count
  always begin
    repeat (2) @(posedge CLK);
    #1 RX_RATE_TICK = 1'b1;
    @(posedge CLK);
    #1 RX_RATE_TICK = 1'b0;
  end
  always @(posedge CLK) starts = starts + CONV_A_START + CONV_B_START;

  // Storable bits of a register
  function automatic logic [7:0] keep(input logic [5:0] ad);
    keep = ad == ADDR_LEVEL_POWERDOWN ? 8'h07 :
      ad == ADDR_DENSITY_B ? 8'h0f : 8'hff;
  endfunction : keep

  // Output port mirroring a register
  function automatic logic [7:0] seen(input logic [5:0] ad);
    case (ad)
      ADDR_LEVEL_A: seen = LEVEL_A;
      ADDR_LEVEL_B: seen = LEVEL_B;
      ADDR_LEVEL_C: seen = LEVEL_C;
      ADDR_LEVEL_POWERDOWN: seen = {5'h00, LEVEL_POWERDOWN};
      ADDR_DENSITY_A: seen = DENSITY_LEVEL_WORD[11:4];
      ADDR_DENSITY_B: seen = {4'h0, DENSITY_LEVEL_WORD[3:0]};
      ADDR_TRIM_A: seen = RECEIVE_BIAS_TRIM_A;
      default: seen = RECEIVE_BIAS_TRIM_B;
    endcase
  endfunction : seen

  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    host.xfer({2'b00, ad}, {d, 8'h00}, 16, rd);
  endtask : wr

  task automatic rdc(input logic [5:0] ad, input logic [7:0] e);
    host.xfer({2'b10, ad}, 16'h0000, 16, rd);
    `CHK("read", e, rd)
  endtask : rdc

  task automatic report_and_stop;
    if (error_cnt == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // Hang guard
  initial begin
    repeat (100000) @(posedge CLK);
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    void'($urandom(32'h0000_5c13));
    repeat (6) @(posedge CLK);
    #1 RST = 1'b0;
    `CHK("ctrl0", 6'h00, ctrl)
    `CHK("pdn0", 3'h0, LEVEL_POWERDOWN)
    rdc(ADDR_LEVEL_A, 8'h00);
    rdc(ADDR_DENSITY_B, 8'h00);
    wr(ADDR_REVISION, ~REV);
    rdc(ADDR_REVISION, REV);
    rdc(6'h00, 8'h00);
    for (int n = 0; n < 24; n++) begin
      a = rw_addr[$urandom % 8];
      x = 8'($urandom);
      LSB_FIRST = 1'($urandom);
      THREE_WIRE_SELECT = 1'($urandom);
      wr(a, x);
      `CHK("port", x & keep(a), seen(a))
      rdc(a, x & keep(a));
    end
    LSB_FIRST = 1'b0;
    host.xfer({2'b01, ADDR_LEVEL_B}, {x, ~x}, 24, rd);
    `CHK("two msb", {x, ~x}, {LEVEL_B, LEVEL_A})
    LSB_FIRST = 1'b1;
    host.xfer({2'b01, ADDR_DENSITY_A}, {x, ~x}, 24, rd);
    `CHK("two lsb", {x, ~x[3:0]}, DENSITY_LEVEL_WORD)
    host.xfer({2'b00, ADDR_LEVEL_A}, {x, 8'h00}, 15, rd);
    `CHK("short", ~x, LEVEL_A)
    starts = 0;
    wr(ADDR_CONV_CTRL, 8'hff);
    `CHK("ctrl", 6'h3f, ctrl)
    `CHK("starts", 2, starts)
    rdc(ADDR_CONV_CTRL, 8'hf6);
    for (int i = 0; i < 2; i++) begin
      r = 10'($urandom);
      wr(ADDR_CONV_CTRL, i ? 8'h08 : 8'h03);
      rdc(i ? 6'h1e : 6'h1c, 8'h00);
      CONV_A_DATA = r;
      CONV_B_DATA = r;
      {CONV_B_DONE, CONV_A_DONE} = i ? 2'b10 : 2'b01;
      @(posedge CLK);
      #1 {CONV_B_DONE, CONV_A_DONE} = 2'b00;
      CONV_A_DATA = ~r;
      CONV_B_DATA = ~r;
      rdc(i ? 6'h1e : 6'h1c, r[9:2]);
      rdc(i ? 6'h1f : 6'h1d, {6'h00, r[1:0]});
    end
    x = 8'($urandom) | 8'h01;
    wr(ADDR_LEVEL_C, 8'h3c);
    wr(ADDR_LEVEL_UPDATE, 8'h80);
    wr(ADDR_LEVEL_C, x);
    `CHK("held", 8'h3c, LEVEL_C)
    wr(ADDR_LEVEL_UPDATE, 8'h84);
    `CHK("applied", x, LEVEL_C)
    rdc(ADDR_LEVEL_UPDATE, 8'h80);
    wr(ADDR_LEVEL_UPDATE, 8'h00);
    wr(ADDR_LEVEL_INVERT, 8'h10);
    `CHK("inverted", ~x, LEVEL_C)
    wr(ADDR_CONV_CLOCK, 8'h01);
    rdc(ADDR_CONV_CLOCK, 8'h01);
    report_and_stop();
  end
endmodule : serial_control_port_aux_regs_tb_top
`default_nettype wire
